// [hw/eep_dev.sv]
// eep_dev: command handling of the memory device for whole-array erase, sleep, wake and
// deepest sleep, with the status read that reports the write latch and the busy flag.
// assumes chip select idles high, mode 0/3 framing, and cs_n low at least 30 ns after the
// eighth rising clock edge; srst_i stands for power-on reset.
//
// How it works
// - finished erase leaves whole array all ones
// - erase ignored unless write unlock latch set
// - both erase opcodes act the same
// - erase opcode alone, chip select rise starts it
// - busy flag reported while erase runs
// - sleep ignores everything but the wake command
// - sleep opcode then chip select rise sleeps
// - only wake command leaves sleep
// - wake starts on eighth rising clock edge
// - read or write only after recovery time
// - deepest sleep entered within entry time
// - deepest sleep ignores all commands
// - bits after deepest sleep opcode ignored
// - short deepest sleep opcode aborts to standby
// - power cycle comes up in standby
// - deepest sleep ignored during erase cycle
// - chip select pulse wakes within exit time
// - frame before exit time elapses does nothing
// - early first bit wakes but drops command
// - power cycle restores power-on register defaults
// - latch cleared by power-up, lock, erase, sleep
// - busy flag is status bit zero
`timescale 1ns/100ps
module eep_dev
	import eep_pkg::*;
#(
	parameter int ERASE_CYCLES = ERASE_CYC,
	parameter int WAKE_CYCLES = WAKE_RECOVERY_CYC,
	parameter int ENTRY_CYCLES = DEEP_SLEEP_ENTRY_CYC,
	parameter int EXIT_CYCLES = DEEP_SLEEP_EXIT_CYC
) (
	input wire logic sys_clk_i, // system clock, drives all self-timed delays
	input wire logic srst_i, // synchronous power-on reset, active high
	input wire logic ce_i, // clock enable of the system domain
	eep_spi_if.device bus, // serial link, clocked by its own sck
	output eep_mode_t mode_o, // current power and busy mode
	output logic wel_o, // write unlock latch
	output logic wip_o, // internal cycle active flag
	output logic array_blank_o // whole array reads all ones
);

	////////////////////////////////////////////////////////////////////////////////////////
	// declarations
	eep_dsys_t q;
	eep_dsys_t n;
	eep_dlink_t lq;
	eep_dlink_t ln;
	logic done_rise;
	logic cs_rise;
	logic cs_fall;
	logic timer_out;
	logic [7:0] stat;
	logic sdo_q;
	logic oe_q;

	////////////////////////////////////////////////////////////////////////////////////////
	// link domain: opcode shifter on the serial clock
	// the whole frame state clears while chip select is high, so a frame cut short leaves
	// nothing behind; the sck stands still between frames, so nothing here waits for an edge
	// after the last one
	always_comb begin
		ln = lq;
		ln.st_s1 = {q.quiet, q.write_unlock_latch, q.internal_cycle_active_flag}; // status resync into the sck domain
		ln.st_s2 = lq.st_s1;
		ln.started = 1'b1; // a first bit has been clocked in this frame
		if (!lq.done) begin
			ln.sh = {lq.sh[5:0], bus.sdi};
			ln.cnt = lq.cnt + 3'd1;
			if (lq.cnt == 3'd7) begin
				ln.done = 1'b1;
				ln.op = {lq.sh, bus.sdi};
				// status read answered unless some sleep mode holds the device
				ln.rd = ({lq.sh, bus.sdi} == OP_STATUS_READ) && !lq.st_s2[2];
			end
		end else if (lq.rd) begin
			ln.idx = lq.idx + 3'd1;
		end
		// once done, later bits are simply not shifted in
	end

	// frame state reset by chip select high
	always_ff @(posedge bus.sck or posedge bus.cs_n) begin
		if (bus.cs_n) begin
			lq <= DLINK_RST;
		end else begin
			lq <= ln;
		end
	end

	// status byte built from the resynchronised flags
	always_comb begin
		stat = 8'h00;
		stat[STAT_WIP_BIT] = lq.st_s2[0];
		stat[STAT_WEL_BIT] = lq.st_s2[1];
	end

	// output data changes on the falling edge so the host samples it stable late in the high half;
	// the byte repeats for as long as the host keeps clocking
	always_ff @(negedge bus.sck or posedge bus.cs_n) begin
		if (bus.cs_n) begin
			sdo_q <= 1'b0;
			oe_q <= 1'b0;
		end else begin
			sdo_q <= stat[3'd7 - lq.idx];
			oe_q <= lq.rd;
		end
	end

	assign bus.sdo = sdo_q;
	assign bus.sdo_oe = oe_q;

	////////////////////////////////////////////////////////////////////////////////////////
	// system domain: crossings and edge detection
	// cs_n and the done level each pass two flops first; cs rise is taken one stage later
	// than done rise so a complete opcode is always latched before the frame end is seen
	assign done_rise = q.done_s[1] & ~q.done_s[2];
	assign cs_rise = q.cs_s[2] & ~q.cs_s[3];
	assign cs_fall = ~q.cs_s[2] & q.cs_s[3];
	assign timer_out = (q.timer == '0);

	////////////////////////////////////////////////////////////////////////////////////////
	// system domain: mode machine and command execution
	always_comb begin
		n = q;
		n.cs_s = {q.cs_s[2:0], bus.cs_n};
		n.done_s = {q.done_s[1:0], lq.done};
		n.go_s = {q.go_s[0], lq.started};
		if (!timer_out) begin
			n.timer = q.timer - 24'h000001;
		end
		// the word is stable from the eighth edge until chip select rises, so one latch suffices
		if (done_rise) begin
			n.pend = 1'b1;
			n.pend_op = lq.op;
		end
		// any frame begun while not in standby is voided, except the wake fall in deepest sleep
		if (q.mode != EEP_STANDBY && q.mode != EEP_DEEP && (q.go_s[1] || cs_fall)) begin
			n.void_fr = 1'b1;
		end
		unique case (q.mode)
			EEP_STANDBY: begin
				// commands act on the chip select rise that ends a whole opcode
				if (cs_rise && q.pend && !q.void_fr) begin
					case (q.pend_op)
						OP_WRITE_UNLOCK: n.write_unlock_latch = 1'b1;
						OP_WRITE_LOCK: n.write_unlock_latch = 1'b0;
						OP_ERASE_A, OP_ERASE_B: begin
							if (q.write_unlock_latch) begin
								n.write_unlock_latch = 1'b0;
								n.internal_cycle_active_flag = 1'b1;
								n.blank = 1'b0;
								n.mode = EEP_ERASING;
								n.timer = TIMER_W'(ERASE_CYCLES);
							end
						end
						OP_SLEEP: begin
							n.write_unlock_latch = 1'b0;
							n.mode = EEP_SLEEP;
						end
						OP_DEEPEST: begin
							if (!q.internal_cycle_active_flag) begin
								n.mode = EEP_DEEP_ENTER;
								n.timer = TIMER_W'(ENTRY_CYCLES);
							end
						end
						default: begin
						end
					endcase
				end
			end
			EEP_ERASING: begin
				// only status read works meanwhile; it is served in the link domain
				if (timer_out) begin
					n.internal_cycle_active_flag = 1'b0;
					n.blank = 1'b1;
					n.mode = EEP_STANDBY;
				end
			end
			EEP_SLEEP: begin
				// nothing but the wake opcode is looked at, and it acts at the eighth edge
				if (done_rise && lq.op == OP_WAKE) begin
					n.mode = EEP_WAKING;
					n.timer = TIMER_W'(WAKE_CYCLES);
				end
			end
			EEP_WAKING: begin
				if (timer_out) begin
					n.mode = EEP_STANDBY;
				end
			end
			EEP_DEEP_ENTER: begin
				if (timer_out) begin
					n.mode = EEP_DEEP;
				end
			end
			EEP_DEEP: begin
				// every opcode is ignored; only the chip select fall leads out
				if (cs_fall) begin
					n.mode = EEP_DEEP_EXIT;
					n.timer = TIMER_W'(EXIT_CYCLES);
				end
			end
			EEP_DEEP_EXIT: begin
				if (timer_out) begin
					n.mode = EEP_STANDBY;
				end
			end
			default: begin
				n.mode = EEP_STANDBY;
			end
		endcase
		// a frame end always consumes the latched opcode, whether acted on or not
		if (cs_rise) begin
			n.pend = 1'b0;
			n.void_fr = 1'b0;
		end
		n.quiet = !(n.mode == EEP_STANDBY || n.mode == EEP_ERASING);
	end

	// power-on reset lands in standby with every flag at its default
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			q <= DSYS_RST;
		end else if (ce_i) begin
			q <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// user-side outputs, all straight from flops
	assign mode_o = q.mode;
	assign wel_o = q.write_unlock_latch;
	assign wip_o = q.internal_cycle_active_flag;
	assign array_blank_o = q.blank;

endmodule : eep_dev

// [hw/eep_pkg.sv]
// eep_pkg: opcodes, timing, state encodings and state records shared by both ends of the
// serial memory link (device-side command handling and the host-side controller).
// assumes a 100 MHz system clock on both ends; long waits are also module parameters.
package eep_pkg;

	////////////////////////////////////////////////////////////////////////////////////////
	// opcodes, shifted msb first
	localparam logic [7:0] OP_WRITE_LOCK = 8'h04;
	localparam logic [7:0] OP_STATUS_READ = 8'h05;
	localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
	localparam logic [7:0] OP_ERASE_A = 8'h60;
	localparam logic [7:0] OP_ERASE_B = 8'hc7;
	localparam logic [7:0] OP_DEEPEST = 8'h79;
	localparam logic [7:0] OP_WAKE = 8'hab;
	localparam logic [7:0] OP_SLEEP = 8'hb9;

	// status byte field positions
	localparam int STAT_WIP_BIT = 0;
	localparam int STAT_WEL_BIT = 1;

	////////////////////////////////////////////////////////////////////////////////////////
	// times in ns and their cycle counts at the system clock
	localparam int SYS_CLK_PERIOD_NS = 10;
	localparam int WAKE_RECOVERY_TIME_NS = 75000;
	localparam int WAKE_RECOVERY_CYC = (WAKE_RECOVERY_TIME_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
	localparam int ERASE_TIME_NS = 2000000;
	localparam int ERASE_CYC = (ERASE_TIME_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
	localparam int DEEP_SLEEP_ENTRY_TIME_NS = 3000;
	localparam int DEEP_SLEEP_ENTRY_CYC = DEEP_SLEEP_ENTRY_TIME_NS / SYS_CLK_PERIOD_NS;
	localparam int DEEP_SLEEP_EXIT_TIME_NS = 70000;
	localparam int DEEP_SLEEP_EXIT_CYC = DEEP_SLEEP_EXIT_TIME_NS / SYS_CLK_PERIOD_NS;
	localparam int WAKE_PULSE_MIN_LOW_TIME_NS = 1000;
	localparam int WAKE_PULSE_MIN_LOW_CYC = (WAKE_PULSE_MIN_LOW_TIME_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
	localparam int TIMER_W = 24;
	// host serial clock: half period and idle gap between frames, in system cycles
	localparam int HOST_HALF_CYC = 4;
	localparam int HOST_GAP_CYC = 8;

	////////////////////////////////////////////////////////////////////////////////////////
	// encodings
	typedef enum logic [2:0] {
		EEP_STANDBY = 3'b000,
		EEP_ERASING = 3'b001,
		EEP_SLEEP = 3'b010,
		EEP_WAKING = 3'b011,
		EEP_DEEP_ENTER = 3'b100,
		EEP_DEEP = 3'b101,
		EEP_DEEP_EXIT = 3'b110
	} eep_mode_t;

	typedef enum logic [1:0] {
		EEP_REQ_OP = 2'b00,
		EEP_REQ_STATUS = 2'b01,
		EEP_REQ_ERASE = 2'b10,
		EEP_REQ_WAKE_PULSE = 2'b11
	} eep_req_t;

	typedef enum logic [2:0] {
		EEP_H_IDLE = 3'b000,
		EEP_H_LO = 3'b001,
		EEP_H_HI = 3'b010,
		EEP_H_END = 3'b011,
		EEP_H_GAP = 3'b100,
		EEP_H_PULSE = 3'b101
	} eep_hstate_t;

	////////////////////////////////////////////////////////////////////////////////////////
	// state records and their reset values
	typedef struct packed {
		logic [3:0] cs_s;
		logic [2:0] done_s;
		logic [1:0] go_s;
		eep_mode_t mode;
		logic write_unlock_latch;
		logic internal_cycle_active_flag;
		logic blank;
		logic quiet;
		logic pend;
		logic void_fr;
		logic [7:0] pend_op;
		logic [TIMER_W-1:0] timer;
	} eep_dsys_t;

	localparam eep_dsys_t DSYS_RST = '{cs_s: 4'hf, done_s: 3'h0, go_s: 2'h0, mode: EEP_STANDBY,
		write_unlock_latch: 1'b0, internal_cycle_active_flag: 1'b0, blank: 1'b0, quiet: 1'b0, pend: 1'b0, void_fr: 1'b0,
		pend_op: 8'h00, timer: 24'h000000};

	typedef struct packed {
		logic [2:0] cnt;
		logic done;
		logic started;
		logic rd;
		logic [6:0] sh;
		logic [7:0] op;
		logic [2:0] idx;
		logic [2:0] st_s1;
		logic [2:0] st_s2;
	} eep_dlink_t;

	localparam eep_dlink_t DLINK_RST = '0;

	typedef struct packed {
		eep_hstate_t state;
		eep_req_t kind;
		logic [1:0] stage;
		logic [15:0] tx;
		logic [4:0] nbits;
		logic [7:0] op;
		logic [7:0] rx;
		logic [TIMER_W-1:0] timer;
		logic cs_n;
		logic sck;
		logic sdi;
		logic rdy;
		logic done;
		logic [7:0] status;
		logic [1:0] sdo_s;
	} eep_host_t;

	localparam eep_host_t HOST_RST = '{state: EEP_H_IDLE, kind: EEP_REQ_OP, stage: 2'h0, tx: 16'h0000,
		nbits: 5'h00, op: 8'h00, rx: 8'h00, timer: 24'h000000, cs_n: 1'b1, sck: 1'b0, sdi: 1'b0,
		rdy: 1'b1, done: 1'b0, status: 8'h00, sdo_s: 2'h0};

endpackage : eep_pkg

// [hw/eep_spi_if.sv]
// eep_spi_if: the four-wire serial link between the host controller and the memory device.
// assumes the bench joins both ends; sdo is driven at all times and stays low while sdo_oe is low.
`timescale 1ns/100ps
interface eep_spi_if;
	logic cs_n;
	logic sck;
	logic sdi;
	logic sdo;
	logic sdo_oe;

	modport device (input cs_n, input sck, input sdi, output sdo, output sdo_oe);
	modport host (output cs_n, output sck, output sdi, input sdo, input sdo_oe);
endinterface : eep_spi_if

// [hw/eep_host.sv]
// eep_host: host controller that frames opcodes on the serial link, reads status, runs a
// whole-array erase with its unlock and busy polling, and makes the deepest-sleep wake pulse.
// assumes the device answers status msb first on falling sck; sck is divided from sys_clk_i.
`timescale 1ns/100ps
module eep_host
	import eep_pkg::*;
#(
	parameter int WAKE_CYCLES = WAKE_RECOVERY_CYC,
	parameter int ENTRY_CYCLES = DEEP_SLEEP_ENTRY_CYC,
	parameter int EXIT_CYCLES = DEEP_SLEEP_EXIT_CYC,
	parameter int PULSE_CYCLES = WAKE_PULSE_MIN_LOW_CYC
) (
	input wire logic sys_clk_i, // system clock
	input wire logic srst_i, // synchronous reset, active high
	input wire logic ce_i, // clock enable, freezes all state when low
	input wire logic req_valid_i, // request offered
	input wire eep_req_t req_kind_i, // request kind
	input wire logic [7:0] req_op_i, // opcode for a plain opcode request
	output logic req_ready_o, // idle, request taken when valid
	output logic done_o, // one-cycle pulse when a request has finished
	output logic [7:0] status_o, // last status byte read
	eep_spi_if.host bus // serial link
);

	////////////////////////////////////////////////////////////////////////////////////////
	// declarations
	eep_host_t q;
	eep_host_t n;
	logic timer_out;

	// opens a frame: chip select low, first bit presented before the first rising edge
	function automatic eep_host_t frame_start(eep_host_t s, logic [15:0] bits, logic [4:0] cnt);
		eep_host_t r;
		r = s;
		r.state = EEP_H_LO;
		r.cs_n = 1'b0;
		r.sck = 1'b0;
		r.sdi = bits[15];
		r.tx = {bits[14:0], 1'b0};
		r.nbits = cnt;
		r.op = bits[15:8];
		r.timer = TIMER_W'(HOST_HALF_CYC);
		return r;
	endfunction : frame_start

	assign timer_out = (q.timer == '0);

	////////////////////////////////////////////////////////////////////////////////////////
	// sequencer
	always_comb begin
		n = q;
		n.done = 1'b0;
		n.sdo_s = {q.sdo_s[0], bus.sdo}; // pin resync
		if (!timer_out) begin
			n.timer = q.timer - 24'h000001;
		end
		unique case (q.state)
			EEP_H_IDLE: begin
				if (req_valid_i) begin
					n.kind = req_kind_i;
					n.stage = 2'h0;
					unique case (req_kind_i)
						EEP_REQ_OP: n = frame_start(n, {req_op_i, 8'h00}, 5'd8);
						EEP_REQ_STATUS: n = frame_start(n, {OP_STATUS_READ, 8'h00}, 5'd16);
						EEP_REQ_ERASE: n = frame_start(n, {OP_WRITE_UNLOCK, 8'h00}, 5'd8);
						EEP_REQ_WAKE_PULSE: begin
							n.state = EEP_H_PULSE;
							n.cs_n = 1'b0;
							n.timer = TIMER_W'(PULSE_CYCLES);
						end
					endcase
				end
			end
			EEP_H_LO: begin
				if (timer_out) begin
					n.sck = 1'b1;
					n.state = EEP_H_HI;
					n.timer = TIMER_W'(HOST_HALF_CYC);
				end
			end
			EEP_H_HI: begin
				// sample late in the high half: the resync delay is well inside it
				if (timer_out) begin
					n.sck = 1'b0;
					n.rx = {q.rx[6:0], q.sdo_s[1]};
					n.nbits = q.nbits - 5'd1;
					n.timer = TIMER_W'(HOST_HALF_CYC);
					if (q.nbits == 5'd1) begin
						n.state = EEP_H_END;
					end else begin
						n.state = EEP_H_LO;
						n.sdi = q.tx[15];
						n.tx = {q.tx[14:0], 1'b0};
					end
				end
			end
			EEP_H_END: begin
				// chip select rises a half period after the last edge, ending the frame
				if (timer_out) begin
					n.cs_n = 1'b1;
					n.sdi = 1'b0;
					n.state = EEP_H_GAP;
					if (q.op == OP_STATUS_READ) begin
						n.status = q.rx;
					end
					if (q.op == OP_WAKE) begin
						n.timer = TIMER_W'(WAKE_CYCLES);
					end else if (q.op == OP_DEEPEST) begin
						n.timer = TIMER_W'(ENTRY_CYCLES);
					end else begin
						n.timer = TIMER_W'(HOST_GAP_CYC);
					end
				end
			end
			EEP_H_PULSE: begin
				if (timer_out) begin
					n.cs_n = 1'b1;
					n.state = EEP_H_GAP;
					n.timer = TIMER_W'(EXIT_CYCLES);
				end
			end
			EEP_H_GAP: begin
				// the erase runs unlock, erase, then status polls until the busy flag drops
				if (timer_out) begin
					if (q.kind == EEP_REQ_ERASE && q.stage == 2'h0) begin
						n = frame_start(n, {OP_ERASE_A, 8'h00}, 5'd8);
						n.stage = 2'h1;
					end else if (q.kind == EEP_REQ_ERASE && (q.stage == 2'h1 || q.status[STAT_WIP_BIT])) begin
						n = frame_start(n, {OP_STATUS_READ, 8'h00}, 5'd16);
						n.stage = 2'h2;
					end else begin
						n.state = EEP_H_IDLE;
						n.done = 1'b1;
					end
				end
			end
			default: begin
				n.state = EEP_H_IDLE;
				n.cs_n = 1'b1;
			end
		endcase
		n.rdy = (n.state == EEP_H_IDLE);
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			q <= HOST_RST;
		end else if (ce_i) begin
			q <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////
	// outputs, all from flops
	assign bus.cs_n = q.cs_n;
	assign bus.sck = q.sck;
	assign bus.sdi = q.sdi;
	assign req_ready_o = q.rdy;
	assign done_o = q.done;
	assign status_o = q.status;

endmodule : eep_host

// [dv/eep_sva.sv]
// eep_sva: concurrent checks on the serial link between host and device ends.
// assumes both ends run on sys_clk_i, so the link wires are sampled on that clock.
`timescale 1ns/100ps
module eep_sva
	import eep_pkg::*;
#(
	parameter int PULSE_CYCLES = WAKE_PULSE_MIN_LOW_CYC
) (
	input wire logic sys_clk_i, // system clock
	input wire logic srst_i, // synchronous reset, active high
	input wire logic cs_n, // chip select, active low
	input wire logic sck, // serial clock
	input wire logic sdi, // host to device data
	input wire logic sdo, // device to host data
	input wire logic sdo_oe // device drives sdo
);
	logic [4:0] rises;
	logic [9:0] low_cnt;
	logic [7:0] op_sh;
	logic sck_q;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);

	////////////////////////////////////////////////////////////////////////////////
	// frame bookkeeping: rising clock count, low time and the last eight shifted bits
	always_ff @(posedge sys_clk_i) begin
		sck_q <= sck;
		if (srst_i || cs_n) begin
			rises <= 5'h00;
			low_cnt <= 10'h000;
		end else begin
			low_cnt <= low_cnt + 10'h001;
			if (sck && !sck_q) begin
				rises <= rises + 5'h01;
				op_sh <= {op_sh[6:0], sdi};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	sequence s_idle_gap;
		cs_n [*4];
	endsequence
	property p_gap;
		$rose(cs_n) |-> s_idle_gap;
	endproperty
	a_gap: assert property (p_gap) else $error("chip select high gap too short");
	property p_sck_idle;
		cs_n |-> !sck;
	endproperty
	a_sck_idle: assert property (p_sck_idle) else $error("serial clock not low outside frame");
	property p_sdi_hold;
		sck && $past(sck) |-> $stable(sdi);
	endproperty
	a_sdi_hold: assert property (p_sdi_hold) else $error("data changed while clock high");
	property p_whole_units;
		$rose(cs_n) |-> (rises == 5'd0 || rises == 5'd8 || rises == 5'd16);
	endproperty
	a_whole_units: assert property (p_whole_units) else $error("frame not whole bytes");
	property p_cs_hold;
		$rose(cs_n) |-> !$past(sck, 1) && !$past(sck, 2) && !$past(sck, 3);
	endproperty
	a_cs_hold: assert property (p_cs_hold) else $error("chip select rose too soon after clock");
	property p_pulse_low;
		$rose(cs_n) && rises == 5'd0 |-> low_cnt >= PULSE_CYCLES;
	endproperty
	a_pulse_low: assert property (p_pulse_low) else $error("chip select low time too short");
	property p_oe_after_op;
		sdo_oe |-> rises >= 5'd8;
	endproperty
	a_oe_after_op: assert property (p_oe_after_op) else $error("sdo driven before opcode done");
	property p_oe_status;
		$rose(sdo_oe) |-> op_sh == OP_STATUS_READ;
	endproperty
	a_oe_status: assert property (p_oe_status) else $error("sdo driven for other opcode");
	property p_oe_off;
		cs_n && $past(cs_n) |-> !sdo_oe;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("sdo driven while deselected");
	property p_sdo_edge;
		sdo_oe && $past(sdo_oe) && $changed(sdo) |-> $fell(sck);
	endproperty
	a_sdo_edge: assert property (p_sdo_edge) else $error("sdo changed off falling clock");
endmodule : eep_sva

// [dv/tb_top.sv]
// tb_top: host and device ends joined on one link, plus a bench-driven link into a
// second device for malformed frames. assumes 100 MHz sys clock and a shortened erase wait.
`timescale 1ns/100ps
module tb_top;
	import eep_pkg::*;
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin errors++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
	logic sys_clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic h_valid = 1'b0;
	eep_req_t h_kind = EEP_REQ_OP;
	logic [7:0] h_op = 8'h00;
	logic h_ready, h_done, dev_wel, dev_wip, dev_blank, f_wel;
	logic [7:0] h_status;
	eep_mode_t dev_mode, f_mode;
	logic [7:0] seen;
	int errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	int n;
	eep_spi_if link();
	eep_spi_if link2();

	////////////////////////////////////////////////////////////////////////////////
	// ends under test at their full waits, except a shorter erase; the host's entry wait is padded past
	// the device's frame-end sync delay so a deepest-sleep check never races the mode change
	eep_host #(.ENTRY_CYCLES(320)) eep_host_i (
		.sys_clk_i(sys_clk_i), .srst_i(srst_i), .ce_i(1'b1), .req_valid_i(h_valid), .req_kind_i(h_kind),
		.req_op_i(h_op), .req_ready_o(h_ready), .done_o(h_done), .status_o(h_status), .bus(link));
	eep_dev #(.ERASE_CYCLES(2000)) eep_dev_i (
		.sys_clk_i(sys_clk_i), .srst_i(srst_i), .ce_i(1'b1), .bus(link), .mode_o(dev_mode),
		.wel_o(dev_wel), .wip_o(dev_wip), .array_blank_o(dev_blank));
	eep_dev eep_dev_i2 (
		.sys_clk_i(sys_clk_i), .srst_i(srst_i), .ce_i(1'b1), .bus(link2), .mode_o(f_mode),
		.wel_o(f_wel), .wip_o(), .array_blank_o());
	eep_sva eep_sva_i (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .cs_n(link.cs_n),
		.sck(link.sck), .sdi(link.sdi), .sdo(link.sdo), .sdo_oe(link.sdo_oe));

	initial begin
		forever #5 sys_clk_i = ~sys_clk_i;
	end
	// modes visited, so short passing states are still observed
	always @(posedge sys_clk_i) seen[dev_mode] <= 1'b1;
	// hang guard: the wake (7500), two exit (7000 each) and two erase (2000 each) waits add up to roughly 25500 cycles
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 60000) begin
			errors++;
			close_out();
		end
	end

	task close_out;
		if (errors == 0 && cmp_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : close_out

	////////////////////////////////////////////////////////////////////////////////
	// one host request, offered once ready is seen, then wait for its done pulse
	task automatic req(input eep_req_t k, input logic [7:0] op);
		int i;
		@(negedge sys_clk_i);
		for (i = 0; i < 200 && h_ready !== 1'b1; i++) @(negedge sys_clk_i);
		h_valid = 1'b1;
		h_kind = k;
		h_op = op;
		@(negedge sys_clk_i);
		h_valid = 1'b0;
		for (i = 0; i < 10000 && h_done !== 1'b1; i++) @(negedge sys_clk_i);
		if (h_done !== 1'b1) errors++;
	endtask : req

	// bench-made frame on the second link: nb bits msb first at a 15 ns clock
	task automatic fr(input logic [15:0] d, input int nb);
		int i;
		link2.cs_n = 1'b0;
		#15;
		for (i = 0; i < nb; i++) begin
			link2.sdi = d[15-i];
			#7.5 link2.sck = 1'b1;
			#7.5 link2.sck = 1'b0;
		end
		#32.5 link2.cs_n = 1'b1; // kept off the system clock edges
		link2.sdi = ~link2.sdi; // released line shows no stale bit
		repeat (10) @(negedge sys_clk_i);
	endtask : fr

	task automatic rst_pulse;
		@(negedge sys_clk_i);
		srst_i = 1'b1;
		repeat (10) @(negedge sys_clk_i);
		srst_i = 1'b0;
	endtask : rst_pulse

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		link2.cs_n = 1'b1;
		link2.sck = 1'b0;
		link2.sdi = 1'b0;
		seen = 8'h00;
		repeat (10) @(negedge sys_clk_i);
		srst_i = 1'b0;
		repeat (4) @(negedge sys_clk_i);
		`CHK({dev_mode, dev_wel, dev_wip, dev_blank}, {EEP_STANDBY, 3'b000})
		req(EEP_REQ_OP, OP_WRITE_UNLOCK);
		`CHK(dev_wel, 1'b1)
		req(EEP_REQ_OP, OP_WRITE_LOCK);
		`CHK(dev_wel, 1'b0)
		req(EEP_REQ_OP, OP_ERASE_A);
		`CHK({dev_mode, dev_wip, dev_blank}, {EEP_STANDBY, 2'b00})
		req(EEP_REQ_ERASE, 8'h00);
		`CHK({dev_mode, dev_wel, dev_wip, dev_blank}, {EEP_STANDBY, 3'b001})
		`CHK(h_status, 8'h00)
		// second opcode, then status and deepest sleep while erasing
		req(EEP_REQ_OP, OP_WRITE_UNLOCK);
		req(EEP_REQ_OP, OP_ERASE_B);
		`CHK({dev_mode, dev_wel, dev_wip, dev_blank}, {EEP_ERASING, 3'b010})
		req(EEP_REQ_STATUS, 8'h00);
		`CHK(h_status, 8'h01)
		req(EEP_REQ_OP, OP_DEEPEST);
		`CHK(dev_mode, EEP_ERASING)
		for (n = 0; n < 20; n++) begin
			req(EEP_REQ_STATUS, 8'h00);
			if (h_status[0] === 1'b0) break;
		end
		`CHK({h_status, dev_blank}, {8'h00, 1'b1})
		// sleep: only the wake opcode is honoured
		req(EEP_REQ_OP, OP_WRITE_UNLOCK);
		req(EEP_REQ_OP, OP_SLEEP);
		`CHK({dev_mode, dev_wel}, {EEP_SLEEP, 1'b0})
		req(EEP_REQ_OP, OP_WRITE_UNLOCK);
		req(EEP_REQ_OP, OP_DEEPEST);
		`CHK({dev_mode, dev_wel}, {EEP_SLEEP, 1'b0})
		seen = 8'h00;
		req(EEP_REQ_OP, OP_WAKE);
		`CHK({dev_mode, seen[EEP_WAKING]}, {EEP_STANDBY, 1'b1})
		req(EEP_REQ_OP, OP_WRITE_UNLOCK);
		`CHK(dev_wel, 1'b1)
		// deepest sleep, left by a chip select pulse
		req(EEP_REQ_OP, OP_WRITE_LOCK);
		req(EEP_REQ_OP, OP_DEEPEST);
		`CHK(dev_mode, EEP_DEEP)
		seen = 8'h00;
		req(EEP_REQ_WAKE_PULSE, 8'h00);
		`CHK({dev_mode, seen[EEP_DEEP_EXIT]}, {EEP_STANDBY, 1'b1})
		// deepest sleep, left by a frame whose first bit comes too early
		req(EEP_REQ_OP, OP_DEEPEST);
		req(EEP_REQ_OP, OP_WRITE_UNLOCK);
		`CHK(dev_wel, 1'b0)
		repeat (7000) @(negedge sys_clk_i);
		req(EEP_REQ_OP, OP_WRITE_UNLOCK);
		`CHK({dev_mode, dev_wel}, {EEP_STANDBY, 1'b1})
		// power cycle while in deepest sleep
		req(EEP_REQ_OP, OP_DEEPEST);
		rst_pulse();
		repeat (4) @(negedge sys_clk_i);
		`CHK({dev_mode, dev_wel, dev_wip}, {EEP_STANDBY, 2'b00})
		// short, whole and overlong frames on the bench-driven link
		fr(16'h0600, 7);
		`CHK(f_wel, 1'b0)
		fr(16'h0600, 8);
		`CHK(f_wel, 1'b1)
		fr(16'h7900, 5);
		`CHK(f_mode, EEP_STANDBY)
		fr(16'h79ff, 11);
		repeat (305) @(negedge sys_clk_i);
		`CHK(f_mode, EEP_DEEP)
		close_out();
	end
endmodule : tb_top
